// >>> hdl/gpx_port_regs.sv
/*
 * gpx_port_regs: seven gpio ports with setup, data and logic cell registers,
 * host register access and reset-pattern drive of the host data bus.
 * Assumes host strobes and pin levels are synchronous to clk, and that the
 * logic array sits outside and hands in its enables and cell next values.
 */
// Summary of operation
// - reset-pattern enabled: drive pattern on host data bus during reset, no bus cycle.
// - after reset release the data bus returns to ordinary operation.
// - programming shares port e pins; when active, port e drivers release.
// - function select bit 0 gives host io, 1 gives latched address; ports e,f,g.
// - every port setup register clears to zero at power-up.
// - bit n of each port register belongs to pin n of that port.
// - direction 1 makes an output, 0 an input; all inputs after reset.
// - on ports with array enables, direction or array enable makes an output.
// - port d keeps only the four low direction and drive bits.
// - drive bit 1 gives open drain, 0 push-pull; five ports only.
// - level-in read returns the live pin levels.
// - output value stored, driven on enabled pins, read back.
// - cell read returns outputs; write loads cells not blocked.
// - block bit 1 stops host loads into that cell; resets to 0.
// - input cells capture pins, feed the array, read by host.
// - enable status reads 1 per enabled pin (open drain high included), 0 per disabled pin.
// - registers reached by host read/write cycles at fixed offsets.
// - chip select high disables the register block.
// - port d pins give strobe, logic clock, chip select, high byte write.
`default_nettype none
module gpx_port_regs
    import gpx_pkg::*;
#(
    parameter logic [15:0] RESET_PATTERN    = 16'h0000,
    parameter logic        RESET_PATTERN_EN = 1'b0
) (
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire logic                          host_sel,
    input  wire logic [7:0]                    host_addr,
    input  wire logic [7:0]                    host_wdata,
    input  wire logic                          host_wr,
    input  wire logic                          host_rd,
    output logic      [15:0]                   host_dout,
    output logic                               host_dout_oe_n,
    input  wire logic [GPX_NPORT-1:0][7:0]     pin_in,
    output logic      [GPX_NPORT-1:0][7:0]     pin_out,
    output logic      [GPX_NPORT-1:0][7:0]     pin_oe_n,
    input  wire logic [GPX_NPORT-1:0][7:0]     array_oe,
    input  wire logic [GPX_NPORT-1:0][7:0]     latched_addr,
    input  wire logic [1:0][7:0]               cell_next,
    output logic      [1:0][7:0]               out_cell,
    output logic      [2:0][7:0]               in_cell,
    input  wire logic                          in_circuit_programming,
    output logic                               address_strobe_in,
    output logic                               logic_clock_in,
    output logic                               chip_select_in,
    output logic                               high_byte_write_enable
);

    // implemented pin mask of a port
    function automatic logic [7:0] pin_mask(input logic [2:0] port);
        pin_mask = (port == GPX_PORT_D) ? GPX_PINS_PORT_D : GPX_PINS_FULL;
    endfunction

    // whether a port owns a register kind
    function automatic logic port_has(input logic [6:0] map, input logic [2:0] port);
        port_has = map[port];
    endfunction

    logic [GPX_NPORT-1:0][7:0] func_sel;
    logic [GPX_NPORT-1:0][7:0] direction;
    logic [GPX_NPORT-1:0][7:0] drive_od;
    logic [GPX_NPORT-1:0][7:0] out_value;
    logic [1:0][7:0]           cell_block;
    logic [GPX_NPORT-1:0][7:0] next_func_sel;
    logic [GPX_NPORT-1:0][7:0] next_direction;
    logic [GPX_NPORT-1:0][7:0] next_drive_od;
    logic [GPX_NPORT-1:0][7:0] next_out_value;
    logic [1:0][7:0]           next_cell_block;
    logic [1:0][7:0]           next_out_cell;
    logic [2:0][7:0]           next_in_cell;
    logic [GPX_NPORT-1:0][7:0] drive_en;
    logic                      wr_pending;
    logic [7:0]                wr_addr;
    logic [7:0]                wr_data;
    logic                      next_wr_pending;
    logic [7:0]                next_wr_addr;
    logic [7:0]                next_wr_data;
    logic                      lclk_prev;
    logic                      commit;
    logic [2:0]                wr_port;
    logic [3:0]                wr_reg;
    logic [2:0]                rd_port;
    logic [3:0]                rd_reg;
    logic [7:0]                rd_data;
    logic                      rd_active;

    // dedicated port d roles, straight from the pins
    assign address_strobe_in      = pin_in[GPX_PORT_D][GPX_ROLE_ASTROBE];
    assign logic_clock_in         = pin_in[GPX_PORT_D][GPX_ROLE_LCLK];
    assign chip_select_in         = pin_in[GPX_PORT_D][GPX_ROLE_CSEL];
    assign high_byte_write_enable = pin_in[GPX_PORT_D][GPX_ROLE_HBWE];

    // write capture: address and data follow the bus while the strobe is high,
    // committed on its falling edge so a slow host settles first
    always_comb begin
        next_wr_pending = host_wr && host_sel && !chip_select_in;
        next_wr_addr    = wr_addr;
        next_wr_data    = wr_data;
        if (next_wr_pending) begin
            next_wr_addr = host_addr;
            next_wr_data = host_wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pending <= 1'b0;
            wr_addr    <= 8'h00;
            wr_data    <= 8'h00;
            lclk_prev  <= 1'b0;
        end else begin
            wr_pending <= next_wr_pending;
            wr_addr    <= next_wr_addr;
            wr_data    <= next_wr_data;
            lclk_prev  <= logic_clock_in;
        end
    end

    // chip select rising mid-strobe cancels the write
    assign commit  = wr_pending && !host_wr && !chip_select_in;
    assign wr_port = wr_addr[6:4];
    assign wr_reg  = wr_addr[3:0];

    // setup and data register updates
    always_comb begin
        next_func_sel   = func_sel;
        next_direction  = direction;
        next_drive_od   = drive_od;
        next_out_value  = out_value;
        next_cell_block = cell_block;
        if (commit && !wr_addr[7] && (32'(wr_port) < GPX_NPORT)) begin
            case (wr_reg)
                GPX_REG_FUNC_SEL: begin
                    if (port_has(GPX_HAS_FUNC_SEL, wr_port)) begin
                        next_func_sel[wr_port] = wr_data;
                    end
                end
                GPX_REG_DIRECTION: begin
                    next_direction[wr_port] = wr_data & pin_mask(wr_port);
                end
                GPX_REG_DRIVE: begin
                    if (port_has(GPX_HAS_DRIVE, wr_port)) begin
                        next_drive_od[wr_port] = wr_data & pin_mask(wr_port);
                    end
                end
                GPX_REG_OUT_VALUE: begin
                    next_out_value[wr_port] = wr_data & pin_mask(wr_port);
                end
                GPX_REG_OCELL_BLK: begin
                    if (port_has(GPX_HAS_OCELL, wr_port)) begin
                        next_cell_block[wr_port[0]] = wr_data;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            func_sel   <= '0;
            direction  <= '0;
            drive_od   <= '0;
            out_value  <= '0;
            cell_block <= '0;
        end else begin
            func_sel   <= next_func_sel;
            direction  <= next_direction;
            drive_od   <= next_drive_od;
            out_value  <= next_out_value;
            cell_block <= next_cell_block;
        end
    end

    // output cells: array loads on the logic clock rising edge,
    // host write loads unblocked bits and wins over the array load
    always_comb begin
        next_out_cell = out_cell;
        if (logic_clock_in && !lclk_prev) begin
            next_out_cell = cell_next;
        end
        for (int c = 0; c < 2; c++) begin
            if (commit && !wr_addr[7] && wr_reg == GPX_REG_OCELL && wr_port == 3'(c)) begin
                next_out_cell[c] = (wr_data & ~cell_block[c])
                                 | (next_out_cell[c] & cell_block[c]);
            end
        end
    end

    // input cells follow the pins while the address strobe is high
    always_comb begin
        next_in_cell = in_cell;
        if (address_strobe_in) begin
            next_in_cell = pin_in[2:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_cell <= '0;
            in_cell  <= '0;
        end else begin
            out_cell <= next_out_cell;
            in_cell  <= next_in_cell;
        end
    end

    // pin drivers, one bit per pin of the same port
    always_comb begin
        for (int p = 0; p < GPX_NPORT; p++) begin
            drive_en[p] = direction[p];
            if (port_has(GPX_HAS_ARRAY_OE, 3'(p))) begin
                drive_en[p] = direction[p] | array_oe[p];
            end
            if (3'(p) == GPX_PORT_E && in_circuit_programming) begin
                drive_en[p] = 8'h00;
            end
            drive_en[p] = drive_en[p] & pin_mask(3'(p));
            for (int b = 0; b < 8; b++) begin
                // address out replaces host data on selected pins
                pin_out[p][b] = func_sel[p][b] ? latched_addr[p][b]
                                               : out_value[p][b];
                if (drive_od[p][b]) begin
                    // open drain only pulls low; high is left to the pull-up
                    pin_oe_n[p][b] = !(drive_en[p][b] && !pin_out[p][b]);
                    pin_out[p][b]  = 1'b0;
                end else begin
                    pin_oe_n[p][b] = !drive_en[p][b];
                end
            end
        end
    end

    // read decode, combinational while the read strobe is high
    assign rd_port   = host_addr[6:4];
    assign rd_reg    = host_addr[3:0];
    assign rd_active = host_rd && host_sel && !chip_select_in;

    always_comb begin
        rd_data = GPX_READ_NONE;
        if (!host_addr[7] && (32'(rd_port) < GPX_NPORT)) begin
            case (rd_reg)
                GPX_REG_FUNC_SEL: begin
                    if (port_has(GPX_HAS_FUNC_SEL, rd_port)) begin
                        rd_data = func_sel[rd_port];
                    end
                end
                GPX_REG_DIRECTION: begin
                    rd_data = direction[rd_port];
                end
                GPX_REG_DRIVE: begin
                    if (port_has(GPX_HAS_DRIVE, rd_port)) begin
                        rd_data = drive_od[rd_port];
                    end
                end
                GPX_REG_LEVEL_IN: begin
                    rd_data = pin_in[rd_port] & pin_mask(rd_port);
                end
                GPX_REG_OUT_VALUE: begin
                    rd_data = out_value[rd_port];
                end
                GPX_REG_OCELL: begin
                    if (port_has(GPX_HAS_OCELL, rd_port)) begin
                        rd_data = out_cell[rd_port[0]];
                    end
                end
                GPX_REG_OCELL_BLK: begin
                    if (port_has(GPX_HAS_OCELL, rd_port)) begin
                        rd_data = cell_block[rd_port[0]];
                    end
                end
                GPX_REG_ICELL: begin
                    if (port_has(GPX_HAS_ICELL, rd_port)) begin
                        rd_data = in_cell[rd_port[1:0]];
                    end
                end
                GPX_REG_EN_STATUS: begin
                    if (port_has(GPX_HAS_ARRAY_OE, rd_port)) begin
                        rd_data = drive_en[rd_port];
                    end
                end
                default: begin
                    rd_data = GPX_READ_NONE;
                end
            endcase
        end
    end

    // host data bus: reset pattern only while reset holds and the bus is idle,
    // so the host's own reset-time sampling sees the pattern on all sixteen lines
    always_comb begin
        host_dout      = {8'h00, rd_data};
        host_dout_oe_n = !rd_active;
        if (!arst_n && RESET_PATTERN_EN && !host_rd && !host_wr) begin
            host_dout      = RESET_PATTERN;
            host_dout_oe_n = 1'b0;
        end
    end

endmodule
`default_nettype wire

// >>> include/gpx_pkg.sv
/*
 * gpx_pkg: shared constants for the gpio port block (port setup registers,
 * data registers and logic cell registers of seven ports).
 * Assumes an 8-bit register map addressed as {port index, register index}.
 */
`default_nettype none
package gpx_pkg;
    // port count and port indices
    localparam int          GPX_NPORT  = 7;
    localparam logic [2:0]  GPX_PORT_A = 3'h0;
    localparam logic [2:0]  GPX_PORT_D = 3'h3;
    localparam logic [2:0]  GPX_PORT_E = 3'h4;

    // register indices inside one port window (address bits 3:0)
    localparam logic [3:0]  GPX_REG_FUNC_SEL  = 4'h0;
    localparam logic [3:0]  GPX_REG_DIRECTION = 4'h1;
    localparam logic [3:0]  GPX_REG_DRIVE     = 4'h2;
    localparam logic [3:0]  GPX_REG_LEVEL_IN  = 4'h3;
    localparam logic [3:0]  GPX_REG_OUT_VALUE = 4'h4;
    localparam logic [3:0]  GPX_REG_OCELL     = 4'h5;
    localparam logic [3:0]  GPX_REG_OCELL_BLK = 4'h6;
    localparam logic [3:0]  GPX_REG_ICELL     = 4'h7;
    localparam logic [3:0]  GPX_REG_EN_STATUS = 4'h8;

    // which ports own which register, bit n = port n (A..G)
    localparam logic [6:0]  GPX_HAS_FUNC_SEL  = 7'h70;
    localparam logic [6:0]  GPX_HAS_DRIVE     = 7'h5B;
    localparam logic [6:0]  GPX_HAS_OCELL     = 7'h03;
    localparam logic [6:0]  GPX_HAS_ICELL     = 7'h07;
    localparam logic [6:0]  GPX_HAS_ARRAY_OE  = 7'h27;

    // implemented pins per port; port d has four
    localparam logic [7:0]  GPX_PINS_FULL     = 8'hFF;
    localparam logic [7:0]  GPX_PINS_PORT_D   = 8'h0F;

    // reset values and the answer of an unmapped location
    localparam logic [7:0]  GPX_CFG_RESET     = 8'h00;
    localparam logic [7:0]  GPX_READ_NONE     = 8'h00;

    // dedicated roles of the port d pins
    localparam int          GPX_ROLE_ASTROBE  = 0;
    localparam int          GPX_ROLE_LCLK     = 1;
    localparam int          GPX_ROLE_CSEL     = 2;
    localparam int          GPX_ROLE_HBWE     = 3;
endpackage
`default_nettype wire

// >>> verif/gpx_pin_env.sv
/* gpx_pin_env: the wires and outside devices on the seven ports.
   Assumes ext_level is what pull-ups or far drivers show on released pins. */
`default_nettype none
module gpx_pin_env
    import gpx_pkg::*;
(
    input  wire logic [GPX_NPORT-1:0][7:0] pin_out,
    input  wire logic [GPX_NPORT-1:0][7:0] pin_oe_n,
    input  wire logic [GPX_NPORT-1:0][7:0] ext_level,
    output logic      [GPX_NPORT-1:0][7:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // a driven pin shows the driver, a released one the outside level
    always_comb begin
        for (int p = 0; p < GPX_NPORT; p++) begin
            pin_in[p] = (pin_out[p] & ~pin_oe_n[p]) | (ext_level[p] & pin_oe_n[p]);
        end
    end
endmodule
`default_nettype wire

// >>> verif/gpx_port_regs_sva.sv
/* gpx_port_regs_sva: port-level checks of the gpio register block.
   Assumes it is bound into gpx_port_regs and sees only that module's ports. */
`default_nettype none
module gpx_port_regs_sva
    import gpx_pkg::*;
#(
    parameter logic [15:0] RESET_PATTERN    = 16'h0000,
    parameter logic        RESET_PATTERN_EN = 1'b0
) (
    input wire logic                      clk,
    input wire logic                      arst_n,
    input wire logic                      host_sel,
    input wire logic                      host_wr,
    input wire logic                      host_rd,
    input wire logic [15:0]               host_dout,
    input wire logic                      host_dout_oe_n,
    input wire logic [GPX_NPORT-1:0][7:0] pin_in,
    input wire logic [GPX_NPORT-1:0][7:0] pin_oe_n,
    input wire logic [GPX_NPORT-1:0][7:0] array_oe,
    input wire logic [1:0][7:0]           cell_next,
    input wire logic [1:0][7:0]           out_cell,
    input wire logic [2:0][7:0]           in_cell,
    input wire logic                      in_circuit_programming,
    input wire logic                      address_strobe_in,
    input wire logic                      logic_clock_in,
    input wire logic                      chip_select_in,
    input wire logic                      high_byte_write_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // pattern matters only inside reset, so the reset disable is lifted here
    a_reset_pattern: assert property (@(posedge clk) disable iff (1'b0)
        (!arst_n && RESET_PATTERN_EN && !host_rd && !host_wr)
        |-> (!host_dout_oe_n && host_dout == RESET_PATTERN))
        else $error("reset pattern not on data bus");
    a_bus_release: assert property (!(host_rd && host_sel && !chip_select_in)
        |-> host_dout_oe_n) else $error("data bus driven outside a read");
    a_read_upper: assert property (!host_dout_oe_n |-> host_dout[15:8] == 8'h00)
        else $error("upper read byte not zero");
    a_pin_roles: assert property ({high_byte_write_enable, chip_select_in,
        logic_clock_in, address_strobe_in} == pin_in[GPX_PORT_D][3:0])
        else $error("dedicated port d inputs wrong");
    a_prog_release: assert property (in_circuit_programming
        |-> pin_oe_n[GPX_PORT_E] == 8'hFF) else $error("port e driven during programming");
    a_port_d_upper: assert property (pin_oe_n[GPX_PORT_D][7:4] == 4'hF)
        else $error("absent port d pin driven");
    a_array_enable: assert property (array_oe[5] == 8'hFF |-> pin_oe_n[5] == 8'h00)
        else $error("array enable did not drive port f");
    a_icell_capture: assert property (address_strobe_in
        |=> in_cell == $past(pin_in[2:0])) else $error("input cells missed strobe");
    a_cell_load: assert property (($rose(logic_clock_in) && !host_wr && !$past(host_wr))
        |=> out_cell == $past(cell_next)) else $error("output cells missed clock");
endmodule
bind gpx_port_regs gpx_port_regs_sva #(
    .RESET_PATTERN(RESET_PATTERN),
    .RESET_PATTERN_EN(RESET_PATTERN_EN)
) i_gpx_port_regs_sva (.clk, .arst_n, .host_sel, .host_wr, .host_rd, .host_dout,
    .host_dout_oe_n, .pin_in, .pin_oe_n, .array_oe, .cell_next, .out_cell, .in_cell,
    .in_circuit_programming, .address_strobe_in, .logic_clock_in, .chip_select_in,
    .high_byte_write_enable);
`default_nettype wire

// >>> verif/testbench.sv
/* testbench: register, pin and cell scenarios for gpx_port_regs.
   Assumes gpx_pin_env closes the pins and the checker is bound in. */
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module testbench
    import gpx_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] PAT = 16'hA5C3;
    logic clk = 1'b0, arst_n = 1'b0, host_sel = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
    logic in_circuit_programming = 1'b0, host_dout_oe_n;
    logic address_strobe_in, logic_clock_in, chip_select_in, high_byte_write_enable;
    logic [7:0] host_addr = '0, host_wdata = '0, got_e, exp_q[$], sdir[GPX_NPORT];
    logic [15:0] host_dout;
    logic [GPX_NPORT-1:0][7:0] pin_in, pin_out, pin_oe_n, ext = '0;
    logic [GPX_NPORT-1:0][7:0] array_oe = '0, latched_addr = '0;
    logic [1:0][7:0] cell_next = '0, out_cell;
    logic [2:0][7:0] in_cell;
    int miscompares = 0, cmp_count = 0, cycles = 0;
    gpx_port_regs #(.RESET_PATTERN(PAT), .RESET_PATTERN_EN(1'b1)) i_gpx_port_regs (
        .clk, .arst_n, .host_sel, .host_addr, .host_wdata, .host_wr, .host_rd,
        .host_dout, .host_dout_oe_n, .pin_in, .pin_out, .pin_oe_n, .array_oe,
        .latched_addr, .cell_next, .out_cell, .in_cell, .in_circuit_programming,
        .address_strobe_in, .logic_clock_in, .chip_select_in, .high_byte_write_enable);
    gpx_pin_env i_gpx_pin_env (.pin_out, .pin_oe_n, .ext_level(ext), .pin_in);
    always #10 clk = ~clk;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    // read data is judged at the edge that ends each read strobe
    always @(posedge clk) begin
        if (host_rd && host_sel && !host_dout_oe_n) begin
            got_e = exp_q.pop_front();
            `CHK(host_dout, {8'h00, got_e})
        end
    end
    task automatic print_verdict();
        `CHK(exp_q.size(), 0)
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tk();
        @(posedge clk);
        #1;
    endtask
    function automatic logic [7:0] ad(input int p, input logic [3:0] r);
        return {1'b0, 3'(p), r};
    endfunction
    // write commits on the edge that sees the strobe low again
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_sel = 1'b1;
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        tk();
        host_wr = 1'b0;
        tk();
        host_sel = 1'b0;
        tk();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host_sel = 1'b1;
        host_addr = a;
        host_rd = 1'b1;
        exp_q.push_back(e);
        tk();
        host_rd = 1'b0;
        host_sel = 1'b0;
        tk();
    endtask
    initial begin
        logic [7:0] dir, drv, dov, msk, de, v;
        void'($urandom(32'h4e42cbd7));
        latched_addr = 56'({$urandom, $urandom});
        cell_next[0] = 8'($urandom);
        repeat (16) @(posedge clk);
        #1;
        `CHK(host_dout, PAT)
        `CHK(host_dout_oe_n, 1'b0)
        arst_n = 1'b1;
        #1;
        `CHK(host_dout_oe_n, 1'b1)
        tk();
        for (int p = 0; p < GPX_NPORT; p++) begin
            rd(ad(p, GPX_REG_DIRECTION), GPX_CFG_RESET);
            if (GPX_HAS_FUNC_SEL[p]) rd(ad(p, GPX_REG_FUNC_SEL), GPX_CFG_RESET);
            if (GPX_HAS_DRIVE[p]) rd(ad(p, GPX_REG_DRIVE), GPX_CFG_RESET);
            if (GPX_HAS_OCELL[p]) rd(ad(p, GPX_REG_OCELL_BLK), GPX_CFG_RESET);
        end
        rd(8'h80, GPX_READ_NONE);
        rd(ad(7, GPX_REG_DIRECTION), GPX_READ_NONE);
        rd(ad(2, GPX_REG_OCELL), GPX_READ_NONE);
        // random setup per port, then every view of it read back
        for (int p = 0; p < GPX_NPORT; p++) begin
            msk = (p == GPX_PORT_D) ? GPX_PINS_PORT_D : GPX_PINS_FULL;
            dir = 8'($urandom);
            drv = 8'($urandom);
            dov = 8'($urandom);
            ext[p] = (p == GPX_PORT_D) ? 8'h00 : 8'($urandom);
            if (p == GPX_PORT_D) dir = 8'hF0 | (dir & 8'h09); // select, clock stay inputs
            de = GPX_HAS_DRIVE[p] ? drv & msk : 8'h00;
            sdir[p] = dir & msk;
            wr(ad(p, GPX_REG_DIRECTION), dir);
            wr(ad(p, GPX_REG_DRIVE), drv);
            wr(ad(p, GPX_REG_OUT_VALUE), dov);
            rd(ad(p, GPX_REG_DIRECTION), dir & msk);
            rd(ad(p, GPX_REG_DRIVE), de);
            rd(ad(p, GPX_REG_OUT_VALUE), dov & msk);
            v = (~dir & ext[p]) | (dir & ~de & dov) | (dir & de & dov & ext[p]);
            rd(ad(p, GPX_REG_LEVEL_IN), v & msk);
            if (GPX_HAS_ARRAY_OE[p]) rd(ad(p, GPX_REG_EN_STATUS), dir);
        end
        wr(ad(0, GPX_REG_DIRECTION), 8'h00);
        wr(ad(3, GPX_REG_DIRECTION), 8'h00);
        wr(ad(5, GPX_REG_DIRECTION), 8'h00);
        array_oe[0] = 8'hF0;
        array_oe[5] = 8'hFF;
        rd(ad(0, GPX_REG_EN_STATUS), 8'hF0);
        rd(ad(5, GPX_REG_EN_STATUS), 8'hFF);
        array_oe = '0;
        // host loads stop at blocked bits; the logic clock loads all
        wr(ad(0, GPX_REG_OCELL_BLK), 8'h0F);
        wr(ad(0, GPX_REG_OCELL), 8'hFF);
        rd(ad(0, GPX_REG_OCELL), 8'hF0);
        rd(ad(0, GPX_REG_OCELL_BLK), 8'h0F);
        cell_next[1] = 8'($urandom);
        ext[GPX_PORT_D][1] = 1'b1;
        tk();
        tk();
        ext[GPX_PORT_D][1] = 1'b0;
        rd(ad(1, GPX_REG_OCELL), cell_next[1]);
        v = 8'($urandom);
        ext[0] = v;
        ext[GPX_PORT_D][0] = 1'b1;
        tk();
        ext[GPX_PORT_D][0] = 1'b0;
        tk();
        ext[0] = ~v;
        rd(ad(0, GPX_REG_ICELL), v);
        ext[GPX_PORT_D][2] = 1'b1;
        wr(ad(1, GPX_REG_DIRECTION), ~sdir[1]);
        ext[GPX_PORT_D][2] = 1'b0;
        rd(ad(1, GPX_REG_DIRECTION), sdir[1]);
        wr(ad(4, GPX_REG_DRIVE), 8'h00);
        wr(ad(4, GPX_REG_DIRECTION), 8'hFF);
        wr(ad(4, GPX_REG_FUNC_SEL), 8'h01);
        rd(ad(4, GPX_REG_FUNC_SEL), 8'h01);
        `CHK(pin_out[4][0], latched_addr[4][0])
        `CHK(pin_oe_n[4], 8'h00)
        in_circuit_programming = 1'b1;
        tk();
        `CHK(pin_oe_n[4], 8'hFF)
        in_circuit_programming = 1'b0;
        arst_n = 1'b0;
        tk();
        arst_n = 1'b1;
        tk();
        rd(ad(0, GPX_REG_OCELL_BLK), GPX_CFG_RESET);
        print_verdict();
    end
endmodule
`default_nettype wire
